// ### src/dgen_map_crc.sv
/*
 * register-map crc: reference pass, then periodic recheck passes.
 * assumes: i_map_data shows the map byte at o_map_index in the same cycle.
 */
`timescale 1ns/1ps
`include "dgen_regs.svh"

module dgen_map_crc (
	input  wire logic        i_mclk,
	input  wire logic        i_nrst,
	input  wire logic        i_enable,
	input  wire logic [7:0]  i_map_data,
	output logic      [5:0]  o_map_index,
	output logic             o_mismatch
);

	dgen_pkg::dgen_crc_state_t state_r;
	logic [7:0]  crc_r;
	logic [7:0]  ref_r;
	logic        ref_valid_r;
	logic [12:0] wait_r;
	logic [7:0]  crc_nxt;

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		for (int i = 0; i < 8; i++) begin
			x = x[7] ? ((x << 1) ^ `DGEN_CRC_POLY) : (x << 1);
		end
		return x;
	endfunction

	always_comb begin
		crc_nxt = crc8(crc_r, i_map_data);
	end

	// ****************************************************************
	// scan sequencer
	// ****************************************************************
	// reference then recheck
	always_ff @(posedge i_mclk) begin
		if (!i_nrst || !i_enable) begin
			state_r     <= dgen_pkg::DGEN_CRC_IDLE;
			crc_r       <= `DGEN_CRC_INIT;
			ref_r       <= 8'h00;
			ref_valid_r <= 1'b0;
			wait_r      <= 13'h0000;
			o_map_index <= 6'h00;
			o_mismatch  <= 1'b0;
		end else begin
			o_mismatch <= 1'b0;
			unique case (state_r)
				dgen_pkg::DGEN_CRC_IDLE: begin
					state_r     <= dgen_pkg::DGEN_CRC_SCAN;
					crc_r       <= `DGEN_CRC_INIT;
					o_map_index <= 6'h00;
				end
				dgen_pkg::DGEN_CRC_SCAN: begin
					crc_r       <= crc_nxt;
					o_map_index <= o_map_index + 6'h01;
					if (o_map_index == 6'(`DGEN_MAP_WORDS - 1)) begin
						state_r <= dgen_pkg::DGEN_CRC_WAIT;
						wait_r  <= 13'(`DGEN_CRC_WAIT_CYC - 1);
						if (!ref_valid_r) begin
							ref_r       <= crc_nxt;
							ref_valid_r <= 1'b1;
						end else begin
							o_mismatch <= (crc_nxt != ref_r);
						end
					end
				end
				dgen_pkg::DGEN_CRC_WAIT: begin
					wait_r <= wait_r - 13'h0001;
					if (wait_r == 13'h0000) begin
						state_r     <= dgen_pkg::DGEN_CRC_SCAN;
						crc_r       <= `DGEN_CRC_INIT;
						o_map_index <= 6'h00;
					end
				end
				default: begin
					state_r <= dgen_pkg::DGEN_CRC_IDLE;
				end
			endcase
		end
	end

endmodule

// ### src/dgen_pkg.sv
/*
 * types shared by the diagnostic enable block.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package dgen_pkg;

	typedef logic [13:0] dgen_diag_t;

	typedef enum logic [1:0] {
		DGEN_CRC_IDLE = 2'b00,
		DGEN_CRC_SCAN = 2'b01,
		DGEN_CRC_WAIT = 2'b10
	} dgen_crc_state_t;

endpackage

// ### src/dgen_regs.svh
/*
 * register indices, field positions, reset values and timing for the
 * diagnostic enable block.
 * assumes: byte address on the bus is four times the register index.
 */
`ifndef DGEN_REGS_SVH
`define DGEN_REGS_SVH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define DGEN_IDX_ENABLE      8'h72
`define DGEN_IDX_FLAGS       8'h74
`define DGEN_IDX_INT_STATUS  8'h80
`define DGEN_IDX_INT_MASK    8'h81

// ****************************************************************
// fields and reset values
// ****************************************************************
`define DGEN_NDIAG           14
`define DGEN_ENABLE_RESET    16'h0000
`define DGEN_FLAGS_RESET     14'h0000
`define DGEN_BIT_ROM_CRC     0
`define DGEN_BIT_MAP_CRC     1
`define DGEN_BIT_SERIAL      2
`define DGEN_BIT_CONV        3
`define DGEN_BIT_POS_IN      4
`define DGEN_BIT_NEG_IN      5
`define DGEN_BIT_REF_PIN     6
`define DGEN_BIT_REF_MIN     7
`define DGEN_BIT_SRC0        8
`define DGEN_BIT_ANA_REG     12
`define DGEN_BIT_DIG_REG     13

// ****************************************************************
// map crc timing and shape
// ****************************************************************
`define DGEN_CLK_PERIOD_NS   50
`define DGEN_CRC_PERIOD_NS   100000
`define DGEN_CRC_WAIT_CYC    (`DGEN_CRC_PERIOD_NS / `DGEN_CLK_PERIOD_NS)
`define DGEN_MAP_WORDS       64
`define DGEN_CRC_POLY        8'h07
`define DGEN_CRC_INIT        8'hFF

`endif

// ### src/dgen_sticky_flags.sv
/*
 * sticky diagnostic flags, cleared by writing one.
 * assumes: detect is already gated by the enables; cond is the live error, gated by the enables too.
 */
`timescale 1ns/1ps
`include "dgen_regs.svh"

module dgen_sticky_flags (
	input  wire logic              i_mclk,
	input  wire logic              i_nrst,
	input  wire dgen_pkg::dgen_diag_t i_detect,
	input  wire dgen_pkg::dgen_diag_t i_cond,
	input  wire dgen_pkg::dgen_diag_t i_clear,
	output dgen_pkg::dgen_diag_t       o_flags
);

	dgen_pkg::dgen_diag_t flags_nxt;

	always_comb begin
		flags_nxt = (o_flags & ~(i_clear & ~i_cond)) | i_detect;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_flags <= `DGEN_FLAGS_RESET;
		end else begin
			o_flags <= flags_nxt;
		end
	end

endmodule

// ### src/dgen_top.sv
/*
 * diagnostic enable register bank with error flags and interrupt.
 * assumes: Avalon-MM master with waitrequest; monitor inputs are
 * synchronous levels from the analog monitors; conv range is a pulse.
 */
// Behaviour
// - 16-bit enable register at index 0x72, reset all zero
// - any write to enable register pulses filter, control, sequencer reset
// - digital regulator low detection sets its flag while enabled
// - analog regulator low detection sets its flag while enabled
// - each current source drop sets its own compliance flag while enabled
// - reference differential too small sets its flag while enabled
// - three range monitors: reference pin, negative and positive inputs
// - each out-of-range conversion sets the conversion range flag
// - serial enable decides if interface errors reach the serial flag
// - map crc: reference pass, periodic recheck, flag on change
// - rom crc mismatch flagged only in fir_conversion_mode, not user coefficients
// - flags stick; write one clears only once condition has gone or its enable is off
`timescale 1ns/1ps
`include "dgen_regs.svh"

module dgen_top (
	input  wire logic        i_mclk,
	input  wire logic        i_nrst,
	input  wire logic [9:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_dig_reg_low,
	input  wire logic        i_ana_reg_low,
	input  wire logic [3:0]  i_src_compliance_low,
	input  wire logic        i_ref_too_small,
	input  wire logic        i_ref_pin_out_of_range,
	input  wire logic        i_neg_input_out_of_range,
	input  wire logic        i_pos_input_out_of_range,
	input  wire logic        i_conv_done,
	input  wire logic        i_conv_out_of_range,
	input  wire logic        i_serial_error,
	input  wire logic        i_fir_conversion_mode,
	input  wire logic        i_user_coefficients,
	input  wire logic        i_rom_crc_mismatch,
	input  wire logic [7:0]  i_map_data,
	output logic      [5:0]  o_map_index,
	output logic      [15:0] o_diag_enable,
	output logic             o_filter_reset,
	output logic             o_irq
);

	dgen_pkg::dgen_diag_t cond;
	dgen_pkg::dgen_diag_t detect;
	dgen_pkg::dgen_diag_t flags;
	dgen_pkg::dgen_diag_t clear;
	dgen_pkg::dgen_diag_t int_status_r;
	dgen_pkg::dgen_diag_t int_mask_r;
	dgen_pkg::dgen_diag_t en;
	logic        map_mismatch;
	logic        bus_req;
	logic        wr_go;
	logic        rd_go;
	logic [31:0] rdata_nxt;

	function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
		return a[9:2] == idx;
	endfunction

	// ****************************************************************
	// bus handshake
	// ****************************************************************
	// waitrequest drops for one cycle per request: fixed two-cycle answer
	assign bus_req = i_avs_read | i_avs_write;
	assign wr_go   = i_avs_write & ~o_avs_waitrequest;
	assign rd_go   = i_avs_read & ~o_avs_waitrequest;

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
		end
	end

	// ****************************************************************
	// enable register
	// ****************************************************************
	// reserved top bits never stored, so they read as zero
	// enable register reset
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_diag_enable <= `DGEN_ENABLE_RESET;
		end else if (wr_go && hit(i_avs_address, `DGEN_IDX_ENABLE)) begin
			if (i_avs_byteenable[0]) begin
				o_diag_enable[7:0] <= i_avs_writedata[7:0];
			end
			if (i_avs_byteenable[1]) begin
				o_diag_enable[13:8] <= i_avs_writedata[13:8];
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_filter_reset <= 1'b0;
		end else begin
			o_filter_reset <= wr_go && hit(i_avs_address, `DGEN_IDX_ENABLE);
		end
	end

	assign en = o_diag_enable[13:0];

	// ****************************************************************
	// monitor conditions
	// ****************************************************************
	always_comb begin
		cond = '0;
		cond[`DGEN_BIT_DIG_REG] = i_dig_reg_low;
		cond[`DGEN_BIT_ANA_REG] = i_ana_reg_low;
		cond[`DGEN_BIT_SRC0 +: 4] = i_src_compliance_low;
		cond[`DGEN_BIT_REF_MIN] = i_ref_too_small;
		cond[`DGEN_BIT_REF_PIN] = i_ref_pin_out_of_range;
		cond[`DGEN_BIT_NEG_IN] = i_neg_input_out_of_range;
		cond[`DGEN_BIT_POS_IN] = i_pos_input_out_of_range;
		cond[`DGEN_BIT_CONV] = i_conv_done & i_conv_out_of_range;
		cond[`DGEN_BIT_SERIAL] = i_serial_error;
		cond[`DGEN_BIT_MAP_CRC] = map_mismatch;
		cond[`DGEN_BIT_ROM_CRC] = i_rom_crc_mismatch & i_fir_conversion_mode
			& ~i_user_coefficients;
	end

	assign detect = cond & en;

	// ****************************************************************
	// error flags, write one to clear
	// ****************************************************************
	// clear by write one
	assign clear = (wr_go && hit(i_avs_address, `DGEN_IDX_FLAGS))
		? (i_avs_writedata[13:0] & {{6{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}})
		: '0;

	dgen_sticky_flags u_flags (
		.i_mclk   (i_mclk),
		.i_nrst   (i_nrst),
		.i_detect (detect),
		.i_cond   (detect),
		.i_clear  (clear),
		.o_flags  (flags)
	);

	dgen_map_crc u_map_crc (
		.i_mclk      (i_mclk),
		.i_nrst      (i_nrst),
		.i_enable    (en[`DGEN_BIT_MAP_CRC]),
		.i_map_data  (i_map_data),
		.o_map_index (o_map_index),
		.o_mismatch  (map_mismatch)
	);

	// ****************************************************************
	// interrupt status and mask
	// ****************************************************************
	// a read clears status, but a new event in that cycle survives
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			int_status_r <= `DGEN_FLAGS_RESET;
		end else if (rd_go && hit(i_avs_address, `DGEN_IDX_INT_STATUS)) begin
			int_status_r <= detect;
		end else begin
			int_status_r <= int_status_r | detect;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			int_mask_r <= `DGEN_FLAGS_RESET;
		end else if (wr_go && hit(i_avs_address, `DGEN_IDX_INT_MASK)) begin
			if (i_avs_byteenable[0]) begin
				int_mask_r[7:0] <= i_avs_writedata[7:0];
			end
			if (i_avs_byteenable[1]) begin
				int_mask_r[13:8] <= i_avs_writedata[13:8];
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(int_status_r & int_mask_r);
		end
	end

	// ****************************************************************
	// read data
	// ****************************************************************
	// unmapped addresses answer with zero, never stall
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (hit(i_avs_address, `DGEN_IDX_ENABLE)) begin
			rdata_nxt[13:0] = en;
		end else if (hit(i_avs_address, `DGEN_IDX_FLAGS)) begin
			rdata_nxt[13:0] = flags;
		end else if (hit(i_avs_address, `DGEN_IDX_INT_STATUS)) begin
			rdata_nxt[13:0] = int_status_r;
		end else if (hit(i_avs_address, `DGEN_IDX_INT_MASK)) begin
			rdata_nxt[13:0] = int_mask_r;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs_read && o_avs_waitrequest) begin
			o_avs_readdata <= rdata_nxt;
		end
	end

endmodule

// ### testbench/dgen_host_model.sv
/* host model: Avalon-MM master for the register bank.
   assumes: one clock; the bench watchdog ends a hung transfer. */
`timescale 1ns/1ps
module dgen_host_model (
	input  wire logic        i_mclk,
	input  wire logic        i_wait,
	output logic      [9:0]  o_addr,
	output logic             o_rd,
	output logic             o_wr,
	output logic      [31:0] o_wdata,
	output logic      [3:0]  o_be
);
	// ****************
	// one transfer
	// ****************
	initial begin
		o_addr = 10'h000;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 32'h00000000;
		o_be = 4'h0;
	end
	// held until waitrequest is seen low; no latency assumed
	task automatic xfer(input logic w, input logic [7:0] i, input logic [15:0] d);
		@(posedge i_mclk);
		o_addr <= {i, 2'h0};
		o_rd <= ~w;
		o_wr <= w;
		o_wdata <= {16'h0000, d};
		o_be <= 4'h3;
		@(posedge i_mclk);
		while (i_wait) @(posedge i_mclk);
		o_rd <= 1'b0;
		o_wr <= 1'b0;
	endtask
endmodule

// ### testbench/dgen_top_assertions.sv
/* checker for the diagnostic enable bank.
   assumes: bound to dgen_top; one clock, synchronous low reset. */
`timescale 1ns/1ps
`include "dgen_regs.svh"
module dgen_top_checker (
	input wire logic        i_mclk,
	input wire logic        i_nrst,
	input wire logic [9:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic [5:0]  o_map_index,
	input wire logic [15:0] o_diag_enable,
	input wire logic        o_filter_reset,
	input wire logic        o_irq
);
	// ****************
	// bus and enable
	// ****************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	sequence s_taken;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	sequence s_rd_done;
		i_avs_read && !o_avs_waitrequest;
	endsequence
	sequence s_en_wr;
		i_avs_write && !o_avs_waitrequest && i_avs_address[9:2] == `DGEN_IDX_ENABLE;
	endsequence
	a_reset_clears: assert property (disable iff (1'b0) !i_nrst |=>
		o_diag_enable == 16'h0000 && !o_irq && !o_filter_reset) else $error("reset not clean");
	a_answer_next: assert property (s_taken |=> !o_avs_waitrequest)
		else $error("no answer");
	// the enable may move on the edge a write lands, so stable only
	a_read_enable: assert property (s_rd_done ##0 $stable(o_diag_enable)
		##0 i_avs_address[9:2] == `DGEN_IDX_ENABLE |-> o_avs_readdata == {16'h0000, o_diag_enable})
		else $error("enable readback wrong");
	a_high_zero: assert property (s_rd_done |-> o_avs_readdata[31:14] == 18'h00000)
		else $error("reserved bits set");
	a_write_pulse: assert property (s_en_wr |-> ##[1:2] o_filter_reset)
		else $error("no filter reset");
	a_pulse_one: assert property (o_filter_reset |=> !o_filter_reset)
		else $error("filter reset too long");
	a_enable_cause: assert property ($changed(o_diag_enable) |-> $past(i_avs_write)
		|| $past(i_avs_write, 2) || $past(i_avs_write, 3)) else $error("enable moved alone");
	a_scan_step: assert property (o_map_index != 6'h00 |=>
		o_map_index == $past(o_map_index) + 6'h01 || o_map_index == 6'h00)
		else $error("scan skipped");
endmodule
bind dgen_top dgen_top_checker chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_map_index(o_map_index), .o_diag_enable(o_diag_enable),
	.o_filter_reset(o_filter_reset), .o_irq(o_irq));

// ### testbench/diagnostic_enable_control_tb_top.sv
/* bench for the diagnostic enable bank.
   assumes: host model drives the bus; monitors are bench levels. */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("unexpected %0t got %h want %h", $time, a, e); end end
module diagnostic_enable_control_tb_top;
	logic        i_mclk = 1'b0;
	logic        i_nrst = 1'b0;
	logic [13:0] mon = 14'h0000;
	logic        fir = 1'b0;
	logic        usr = 1'b0;
	logic [7:0]  crp = 8'h00;
	logic [9:0]  adr;
	logic        rq;
	logic        wq;
	logic [31:0] wd;
	logic [3:0]  be;
	logic [31:0] rdat;
	logic        wt;
	logic [5:0]  mi;
	logic [15:0] den;
	logic        frst;
	logic        irq;
	logic [31:0] ev;
	logic [31:0] en;
	logic [31:0] exq[$];
	logic [31:0] exp_v;
	int          n_mismatch = 0;
	int          total_checks = 0;
	always #25 i_mclk = ~i_mclk;
	dgen_host_model host (.i_mclk(i_mclk), .i_wait(wt), .o_addr(adr), .o_rd(rq),
		.o_wr(wq), .o_wdata(wd), .o_be(be));
	dgen_top dut (
		.i_mclk(i_mclk), .i_nrst(i_nrst), .i_avs_address(adr), .i_avs_read(rq),
		.i_avs_write(wq), .i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_dig_reg_low(mon[13]),
		.i_ana_reg_low(mon[12]), .i_src_compliance_low(mon[11:8]),
		.i_ref_too_small(mon[7]), .i_ref_pin_out_of_range(mon[6]),
		.i_neg_input_out_of_range(mon[5]), .i_pos_input_out_of_range(mon[4]),
		.i_conv_done(mon[3]), .i_conv_out_of_range(mon[3]), .i_serial_error(mon[2]),
		.i_fir_conversion_mode(fir), .i_user_coefficients(usr),
		.i_rom_crc_mismatch(mon[0]), .i_map_data({2'h0, mi} ^ crp), .o_map_index(mi),
		.o_diag_enable(den), .o_filter_reset(frst), .o_irq(irq));
	// ****************
	// helpers
	// ****************
	// pop once: the compare macro names its expected value twice
	always @(posedge i_mclk) if (rq && !wt) begin
		exp_v = exq.pop_front();
		`CHK(rdat, exp_v)
	end
	task automatic rd(input logic [7:0] i, input logic [15:0] e);
		exq.push_back({16'h0000, e});
		host.xfer(1'b0, i, 16'h0000);
	endtask
	task automatic wr(input logic [7:0] i, input logic [15:0] d);
		host.xfer(1'b1, i, d);
	endtask
	task automatic pulse(input logic [13:0] v);
		mon <= v;
		@(posedge i_mclk);
		mon <= 14'h0000;
		@(posedge i_mclk);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ****************
	// tests
	// ****************
	initial begin
		repeat (20000) @(posedge i_mclk);
		n_mismatch++;
		conclude();
	end
	initial begin
		void'($urandom(96661));
		repeat (12) @(posedge i_mclk);
		i_nrst <= 1'b1;
		@(posedge i_mclk);
		rd(8'h72, 16'h0000);
		rd(8'h90, 16'h0000);
		fir <= 1'b1;
		pulse(14'h3FFF);
		rd(8'h74, 16'h0000);
		rd(8'h80, 16'h0000);
		$display("reset and gating done");
		wr(8'h72, 16'hFFFF);
		#1 `CHK(frst, 1'b1)
		`CHK(den, 16'h3FFF)
		@(posedge i_mclk);
		#1 `CHK(frst, 1'b0)
		// a flag is set, cleared once its cause has gone, then read as zero
		for (int b = 0; b < 14; b++) if (b != 1) begin
			pulse(14'h0001 << b);
			rd(8'h74, 16'h0001 << b);
			wr(8'h74, 16'h0001 << b);
			rd(8'h74, 16'h0000);
		end
		rd(8'h80, 16'h3FFD);
		rd(8'h80, 16'h0000);
		$display("monitors done");
		mon <= 14'h2000;
		wr(8'h74, 16'h2000);
		rd(8'h74, 16'h2000);
		mon <= 14'h0000;
		usr <= 1'b1;
		pulse(14'h0001);
		rd(8'h74, 16'h2000);
		fir <= 1'b0;
		usr <= 1'b0;
		pulse(14'h0001);
		rd(8'h80, 16'h2000);
		wr(8'h81, 16'h2000);
		pulse(14'h2000);
		#1 `CHK(irq, 1'b1)
		rd(8'h80, 16'h2000);
		@(posedge i_mclk);
		#1 `CHK(irq, 1'b0)
		wr(8'h74, 16'h2000);
		$display("sticky and irq done");
		en = $urandom;
		ev = $urandom;
		wr(8'h72, en[15:0]);
		pulse(ev[13:0]);
		rd(8'h74, {2'h0, ev[13:0] & en[13:0] & 14'h3FFC});
		wr(8'h74, 16'h3FFF);
		$display("random gating done");
		wr(8'h72, 16'h0002);
		repeat (2200) @(posedge i_mclk);
		rd(8'h74, 16'h0000);
		crp <= 8'($urandom) | 8'h01;
		repeat (2300) @(posedge i_mclk);
		rd(8'h74, 16'h0002);
		$display("map crc done");
		conclude();
	end
endmodule
